// ===== shared/ccid_defs.svh
`ifndef CCID_DEFS_SVH
`define CCID_DEFS_SVH

// Register byte offsets
`define CCID_OFF_COMM     8'h00
`define CCID_OFF_NODE     8'h04
`define CCID_OFF_DEST     8'h08
`define CCID_OFF_CMD      8'h0C
`define CCID_OFF_STAT     8'h10
`define CCID_OFF_TXID     8'h14
`define CCID_OFF_RXID     8'h18
`define CCID_OFF_PEER_TX  8'h1C
`define CCID_OFF_PEER_RX  8'h20
`define CCID_OFF_POOL     8'h24

// Command bits
`define CCID_CMD_OPEN     0
`define CCID_CMD_CLOSE    1
`define CCID_CMD_EXPL     2
`define CCID_CMD_CLRERR   3

// Status bits
`define CCID_ST_EST       0
`define CCID_ST_ERR       1
`define CCID_ST_TXWAIT    2
`define CCID_ST_RXWAIT    3

// Reset and fixed values
`define CCID_COMM_RST     8'hFF
`define CCID_COMM_EXPL    8'h33
`define CCID_NODE_RST     6'h00
`define CCID_ID_UNUSED    16'hFFFF
`define CCID_ID_MAX       16'h07F0

// Nibble encodings
`define CCID_NIB_G1       4'h0
`define CCID_NIB_G2D      4'h1
`define CCID_NIB_G2S      4'h2
`define CCID_NIB_G3       4'h3
`define CCID_NIB_DEFAULT  4'hF

// Identifier group prefixes
`define CCID_PFX_G1       1'h0
`define CCID_PFX_G2       2'h2
`define CCID_PFX_G3       2'h3

// Pool sizes
`define CCID_G1_IDS       16
`define CCID_G2_IDS       8
`define CCID_G3_IDS       7

`endif

// ===== shared/ccid_pkg.sv
`include "ccid_defs.svh"

package ccid_pkg;

   typedef enum logic [2:0] {
      ROLE_NONE = 3'h0,
      ROLE_G1   = 3'h1,
      ROLE_G2D  = 3'h2,
      ROLE_G2S  = 3'h3,
      ROLE_G3   = 3'h4,
      ROLE_RSVD = 3'h5
   } ccid_role_t;

   typedef enum logic [3:0] {
      ST_IDLE  = 4'h1,
      ST_TX    = 4'h2,
      ST_RX    = 4'h4,
      ST_SHARE = 4'h8
   } ccid_state_t;

   function automatic ccid_role_t ccid_decode(input logic [3:0] nib);
      ccid_role_t r;
      case (nib)
         `CCID_NIB_G1:      r = ROLE_G1;
         `CCID_NIB_G2D:     r = ROLE_G2D;
         `CCID_NIB_G2S:     r = ROLE_G2S;
         `CCID_NIB_G3:      r = ROLE_G3;
         `CCID_NIB_DEFAULT: r = ROLE_NONE;
         default:           r = ROLE_RSVD;
      endcase
      return r;
   endfunction

endpackage

// ===== core/ccid_pool.sv
`timescale 1ns/1ps

module ccid_pool #(
   parameter int N = 8,
   parameter int W = 3
) (
   input  wire logic         clk,
   input  wire logic         rst_b,
   input  wire logic         alloc,
   input  wire logic [N-1:0] free_mask,
   output logic              any_free,
   output logic [W-1:0]      lowest,
   output logic [N-1:0]      used
);

   generate
      if (N < 1 || N > (1 << W)) begin : g_bad
         $error("ccid_pool: N does not fit index width W");
      end
   endgenerate

   logic [N-1:0] sel;

   // Lowest free index wins
   always_comb begin
      any_free = 1'b0;
      lowest   = '0;
      for (int i = N - 1; i >= 0; i--) begin
         if (!used[i]) begin
            any_free = 1'b1;
            lowest   = W'(i);
         end
      end
   end

   genvar k;
   generate
      for (k = 0; k < N; k++) begin : g_flag
         assign sel[k] = alloc && any_free && (lowest == W'(k));
         // Held until the owner releases it
         always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
               used[k] <= 1'b0;
            end else if (sel[k]) begin
               used[k] <= 1'b1;
            end else if (free_mask[k]) begin
               used[k] <= 1'b0;
            end
         end
      end
   endgenerate

endmodule

// ===== core/ccid_idform.sv
`timescale 1ns/1ps
`include "ccid_defs.svh"

module ccid_idform (
   input  wire ccid_pkg::ccid_role_t role,
   input  wire logic [3:0]           msg_id,
   input  wire logic [5:0]           addr,
   output logic [15:0]               ident
);

   always_comb begin
      case (role)
         ccid_pkg::ROLE_G1:
            ident = {5'h00, `CCID_PFX_G1, msg_id, addr};
         ccid_pkg::ROLE_G2D, ccid_pkg::ROLE_G2S:
            ident = {5'h00, `CCID_PFX_G2, addr, msg_id[2:0]};
         ccid_pkg::ROLE_G3:
            ident = {5'h00, `CCID_PFX_G3, msg_id[2:0], addr};
         default:
            ident = `CCID_ID_UNUSED;
      endcase
   end

endmodule

// ===== core/ccid_alloc.sv
// Behaviour
// - Production nibble 0,1,2 means group 1, group 2 dest, group 2 source.
// - Production nibble 3 is group 3; 4..E reserved; F is default.
// - Group 1 production: own pool ID plus own address becomes transmit ID.
// - Always allocate the lowest free message ID of the group pool.
// - A generated transmit ID is passed to every associated consumer.
// - Group 2 dest production carries destination address in address field.
// - Group 2 dest: consumer generates ID; producer copies it in.
// - Group 2 source production uses own address; producer generates it.
// - Group 3 production: own group 3 pool ID plus own address.
// - Consume-only keeps default production nibble; explicit sets it on open.
// - Consumption in lower nibble, production in upper nibble of byte.
// - Consumption nibble 0..3 decode; 4..E reserved; F default.
// - Group 2 dest consumption: lowest free group 2 ID into receive ID.
// - Consumer-generated group 2 dest ID goes to producer's transmit ID.
// - IDs lie in 0..7F0 when used; FFFF marks an unused direction.
// - Never allocate a pair that lets two nodes send the same identifier.
`timescale 1ns/1ps
`include "ccid_defs.svh"

module ccid_alloc #(
   parameter int G1_IDS = `CCID_G1_IDS,
   parameter int G2_IDS = `CCID_G2_IDS,
   parameter int G3_IDS = `CCID_G3_IDS
) (
   input  wire logic        CLK_SYS,
   input  wire logic        RST_B,
   input  wire logic [7:0]  REG_ADDR,
   input  wire logic [31:0] REG_WDATA,
   input  wire logic        REG_WR,
   input  wire logic        REG_RD,
   output logic [31:0]      REG_RDATA,
   output logic [15:0]      TX_ID,
   output logic [15:0]      RX_ID,
   output logic             TX_ID_SHARE,
   output logic             RX_ID_SHARE
);
   // Group 3 ID 7 would exceed the 7F0 maximum for high addresses
   generate
      if (G1_IDS < 1 || G1_IDS > 16 || G2_IDS < 1 || G2_IDS > 8 ||
          G3_IDS < 1 || G3_IDS > 7) begin : g_bad
         $error("ccid_alloc: pool size out of range");
      end
   endgenerate
   function automatic logic [1:0] pool_of(input ccid_pkg::ccid_role_t r);
      logic [1:0] p;
      case (r)
         ccid_pkg::ROLE_G1:  p = 2'h1;
         ccid_pkg::ROLE_G2D: p = 2'h2;
         ccid_pkg::ROLE_G2S: p = 2'h2;
         ccid_pkg::ROLE_G3:  p = 2'h3;
         default:            p = 2'h0;
      endcase
      return p;
   endfunction
   function automatic logic [15:0] one_hot(input logic [3:0] idx);
      logic [15:0] m;
      m = 16'h0000;
      m[idx] = 1'b1;
      return m;
   endfunction
   ccid_pkg::ccid_state_t state_reg;
   ccid_pkg::ccid_state_t state_next;
   ccid_pkg::ccid_role_t  prod_role, cons_role, gen_role;
   ccid_pkg::ccid_role_t  tx_role_reg, rx_role_reg;
   logic [7:0]          comm_reg;
   logic [5:0]          node_reg, dest_reg;
   logic                est_reg, err_reg;
   logic                tx_wait_reg, rx_wait_reg;
   logic                tx_own_reg, rx_own_reg;
   logic [3:0]          tx_mid_reg, rx_mid_reg;
   logic [15:0]         tx_id_reg, rx_id_reg;
   logic [31:0]         rdata_reg, rd_mux;
   logic                wr_comm, wr_node, wr_dest, wr_cmd;
   logic                wr_peer_tx, wr_peer_rx;
   logic                cmd_open, cmd_close, cmd_clrerr;
   logic                peer_tx_ok, peer_rx_ok, gen_ok, sel_free, err_set;
   logic [3:0]          sel_mid, low1;
   logic [15:0]         formed, tx_free, rx_free;
   logic                free1, free2, free3;
   logic [2:0]          low2, low3;
   logic [G1_IDS-1:0]   used1;
   logic [G2_IDS-1:0]   used2;
   logic [G3_IDS-1:0]   used3;
   // Register strobes
   assign wr_comm    = REG_WR && (REG_ADDR == `CCID_OFF_COMM);
   assign wr_node    = REG_WR && (REG_ADDR == `CCID_OFF_NODE);
   assign wr_dest    = REG_WR && (REG_ADDR == `CCID_OFF_DEST);
   assign wr_cmd     = REG_WR && (REG_ADDR == `CCID_OFF_CMD);
   assign wr_peer_tx = REG_WR && (REG_ADDR == `CCID_OFF_PEER_TX);
   assign wr_peer_rx = REG_WR && (REG_ADDR == `CCID_OFF_PEER_RX);
   assign cmd_open   = wr_cmd && REG_WDATA[`CCID_CMD_OPEN] && !est_reg &&
                       (state_reg == ccid_pkg::ST_IDLE);
   assign cmd_close  = wr_cmd && REG_WDATA[`CCID_CMD_CLOSE] && est_reg;
   assign cmd_clrerr = wr_cmd && REG_WDATA[`CCID_CMD_CLRERR];
   // Upper nibble produces, lower consumes
   assign prod_role = ccid_pkg::ccid_decode(comm_reg[7:4]);
   assign cons_role = ccid_pkg::ccid_decode(comm_reg[3:0]);
   // Roles this node generates itself
   always_comb begin
      gen_role = ccid_pkg::ROLE_NONE;
      if (state_reg == ccid_pkg::ST_TX) begin
         if (prod_role == ccid_pkg::ROLE_G1 ||
             prod_role == ccid_pkg::ROLE_G2S ||
             prod_role == ccid_pkg::ROLE_G3) begin
            gen_role = prod_role;
         end
      end else if (state_reg == ccid_pkg::ST_RX) begin
         if (cons_role == ccid_pkg::ROLE_G2D) begin
            gen_role = cons_role;
         end
      end
   end
   always_comb begin
      case (pool_of(gen_role))
         2'h1: begin
            sel_free = free1;
            sel_mid  = low1;
         end
         2'h2: begin
            sel_free = free2;
            sel_mid  = {1'b0, low2};
         end
         2'h3: begin
            sel_free = free3;
            sel_mid  = {1'b0, low3};
         end
         default: begin
            sel_free = 1'b0;
            sel_mid  = 4'h0;
         end
      endcase
   end
   assign gen_ok = (gen_role != ccid_pkg::ROLE_NONE) && sel_free;
   // Own address in every generated ID keeps pairs unique
   ccid_idform u_form (
      .role   (gen_role),
      .msg_id (sel_mid),
      .addr   (node_reg),
      .ident  (formed)
   );
   // Release on close only
   assign tx_free  = (cmd_close && tx_own_reg) ? one_hot(tx_mid_reg) : '0;
   assign rx_free  = (cmd_close && rx_own_reg) ? one_hot(rx_mid_reg) : '0;
   ccid_pool #(.N(G1_IDS), .W(4)) u_pool1 (
      .clk       (CLK_SYS),
      .rst_b     (RST_B),
      .alloc     (gen_ok && pool_of(gen_role) == 2'h1),
      .free_mask (((pool_of(tx_role_reg) == 2'h1) ? tx_free[G1_IDS-1:0] : '0)
                | ((pool_of(rx_role_reg) == 2'h1) ? rx_free[G1_IDS-1:0] : '0)),
      .any_free  (free1),
      .lowest    (low1),
      .used      (used1)
   );
   ccid_pool #(.N(G2_IDS), .W(3)) u_pool2 (
      .clk       (CLK_SYS),
      .rst_b     (RST_B),
      .alloc     (gen_ok && pool_of(gen_role) == 2'h2),
      .free_mask (((pool_of(tx_role_reg) == 2'h2) ? tx_free[G2_IDS-1:0] : '0)
                | ((pool_of(rx_role_reg) == 2'h2) ? rx_free[G2_IDS-1:0] : '0)),
      .any_free  (free2),
      .lowest    (low2),
      .used      (used2)
   );
   ccid_pool #(.N(G3_IDS), .W(3)) u_pool3 (
      .clk       (CLK_SYS),
      .rst_b     (RST_B),
      .alloc     (gen_ok && pool_of(gen_role) == 2'h3),
      .free_mask (((pool_of(tx_role_reg) == 2'h3) ? tx_free[G3_IDS-1:0] : '0)
                | ((pool_of(rx_role_reg) == 2'h3) ? rx_free[G3_IDS-1:0] : '0)),
      .any_free  (free3),
      .lowest    (low3),
      .used      (used3)
   );
   // Peer copies: range checked, and group 2 dest must name the target
   assign peer_tx_ok = wr_peer_tx && tx_wait_reg &&
                       REG_WDATA[31:16] == 16'h0000 &&
                       REG_WDATA[15:0] <= `CCID_ID_MAX &&
                       REG_WDATA[10:9] == `CCID_PFX_G2 &&
                       REG_WDATA[8:3] == dest_reg;
   assign peer_rx_ok = wr_peer_rx && rx_wait_reg &&
                       REG_WDATA[31:16] == 16'h0000 &&
                       REG_WDATA[15:0] <= `CCID_ID_MAX;
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ccid_pkg::ST_IDLE:  if (cmd_open) state_next = ccid_pkg::ST_TX;
         ccid_pkg::ST_TX:    state_next = ccid_pkg::ST_RX;
         ccid_pkg::ST_RX:    state_next = ccid_pkg::ST_SHARE;
         ccid_pkg::ST_SHARE: state_next = ccid_pkg::ST_IDLE;
         default:            state_next = ccid_pkg::ST_IDLE;
      endcase
   end
   always_ff @(posedge CLK_SYS or negedge RST_B) begin
      if (!RST_B) begin
         state_reg <= ccid_pkg::ST_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end
   // Characteristics byte is frozen while the connection is open
   always_ff @(posedge CLK_SYS or negedge RST_B) begin
      if (!RST_B) begin
         comm_reg <= `CCID_COMM_RST;
      end else if (cmd_open && REG_WDATA[`CCID_CMD_EXPL]) begin
         comm_reg <= `CCID_COMM_EXPL;
      end else if (wr_comm && !est_reg && state_reg == ccid_pkg::ST_IDLE) begin
         comm_reg <= REG_WDATA[7:0];
      end
   end
   always_ff @(posedge CLK_SYS or negedge RST_B) begin
      if (!RST_B) begin
         node_reg <= `CCID_NODE_RST;
         dest_reg <= `CCID_NODE_RST;
      end else if (!est_reg && state_reg == ccid_pkg::ST_IDLE) begin
         if (wr_node) node_reg <= REG_WDATA[5:0];
         if (wr_dest) dest_reg <= REG_WDATA[5:0];
      end
   end
   always_ff @(posedge CLK_SYS or negedge RST_B) begin
      if (!RST_B) begin
         est_reg <= 1'b0;
      end else if (state_reg == ccid_pkg::ST_SHARE) begin
         est_reg <= 1'b1;
      end else if (cmd_close) begin
         est_reg <= 1'b0;
      end
   end
   // Transmit side
   always_ff @(posedge CLK_SYS or negedge RST_B) begin
      if (!RST_B) begin
         tx_id_reg   <= `CCID_ID_UNUSED;
         tx_wait_reg <= 1'b0;
         tx_own_reg  <= 1'b0;
         tx_mid_reg  <= 4'h0;
         tx_role_reg <= ccid_pkg::ROLE_NONE;
      end else if (state_reg == ccid_pkg::ST_TX) begin
         tx_role_reg <= prod_role;
         tx_mid_reg  <= sel_mid;
         tx_own_reg  <= gen_ok;
         tx_wait_reg <= (prod_role == ccid_pkg::ROLE_G2D);
         tx_id_reg   <= gen_ok ? formed : `CCID_ID_UNUSED;
      end else if (peer_tx_ok) begin
         tx_id_reg   <= REG_WDATA[15:0];
         tx_wait_reg <= 1'b0;
      end else if (cmd_close) begin
         tx_id_reg   <= `CCID_ID_UNUSED;
         tx_wait_reg <= 1'b0;
         tx_own_reg  <= 1'b0;
      end
   end
   // Receive side
   always_ff @(posedge CLK_SYS or negedge RST_B) begin
      if (!RST_B) begin
         rx_id_reg   <= `CCID_ID_UNUSED;
         rx_wait_reg <= 1'b0;
         rx_own_reg  <= 1'b0;
         rx_mid_reg  <= 4'h0;
         rx_role_reg <= ccid_pkg::ROLE_NONE;
      end else if (state_reg == ccid_pkg::ST_RX) begin
         rx_role_reg <= cons_role;
         rx_mid_reg  <= sel_mid;
         rx_own_reg  <= gen_ok;
         rx_wait_reg <= (cons_role == ccid_pkg::ROLE_G1 ||
                         cons_role == ccid_pkg::ROLE_G2S ||
                         cons_role == ccid_pkg::ROLE_G3);
         rx_id_reg   <= gen_ok ? formed : `CCID_ID_UNUSED;
      end else if (peer_rx_ok) begin
         rx_id_reg   <= REG_WDATA[15:0];
         rx_wait_reg <= 1'b0;
      end else if (cmd_close) begin
         rx_id_reg   <= `CCID_ID_UNUSED;
         rx_wait_reg <= 1'b0;
         rx_own_reg  <= 1'b0;
      end
   end
   // Reserved nibble, empty pool or refused write; set beats clear
   assign err_set =
      (state_reg == ccid_pkg::ST_TX &&
       (prod_role == ccid_pkg::ROLE_RSVD ||
        (gen_role != ccid_pkg::ROLE_NONE && !sel_free))) ||
      (state_reg == ccid_pkg::ST_RX &&
       (cons_role == ccid_pkg::ROLE_RSVD ||
        (gen_role != ccid_pkg::ROLE_NONE && !sel_free))) ||
      (wr_peer_tx && !peer_tx_ok) || (wr_peer_rx && !peer_rx_ok) ||
      ((wr_comm || wr_node || wr_dest) &&
       (est_reg || state_reg != ccid_pkg::ST_IDLE));
   always_ff @(posedge CLK_SYS or negedge RST_B) begin
      if (!RST_B) begin
         err_reg <= 1'b0;
      end else if (err_set) begin
         err_reg <= 1'b1;
      end else if (cmd_clrerr) begin
         err_reg <= 1'b0;
      end
   end
   // Hand generated IDs to the connection objects at the other end
   assign TX_ID_SHARE = (state_reg == ccid_pkg::ST_SHARE) && tx_own_reg;
   assign RX_ID_SHARE = (state_reg == ccid_pkg::ST_SHARE) && rx_own_reg;
   assign TX_ID       = tx_id_reg;
   assign RX_ID       = rx_id_reg;
   always_comb begin
      rd_mux = 32'h0000_0000;
      if (REG_ADDR == `CCID_OFF_COMM) begin
         rd_mux[7:0] = comm_reg;
      end else if (REG_ADDR == `CCID_OFF_NODE) begin
         rd_mux[5:0] = node_reg;
      end else if (REG_ADDR == `CCID_OFF_DEST) begin
         rd_mux[5:0] = dest_reg;
      end else if (REG_ADDR == `CCID_OFF_STAT) begin
         rd_mux[`CCID_ST_EST]    = est_reg;
         rd_mux[`CCID_ST_ERR]    = err_reg;
         rd_mux[`CCID_ST_TXWAIT] = tx_wait_reg;
         rd_mux[`CCID_ST_RXWAIT] = rx_wait_reg;
      end else if (REG_ADDR == `CCID_OFF_TXID) begin
         rd_mux[15:0] = tx_id_reg;
      end else if (REG_ADDR == `CCID_OFF_RXID) begin
         rd_mux[15:0] = rx_id_reg;
      end else if (REG_ADDR == `CCID_OFF_POOL) begin
         rd_mux[G1_IDS-1:0]  = used1;
         rd_mux[16+G2_IDS-1:16] = used2;
         rd_mux[24+G3_IDS-1:24] = used3;
      end
   end
   // Data only in the cycle after the strobe; zero otherwise
   always_ff @(posedge CLK_SYS or negedge RST_B) begin
      if (!RST_B) begin
         rdata_reg <= 32'h0000_0000;
      end else begin
         rdata_reg <= REG_RD ? rd_mux : 32'h0000_0000;
      end
   end
   assign REG_RDATA = rdata_reg;
endmodule

// ===== tb/ccid_peer.sv
`timescale 1ns/1ps

module ccid_peer (
   input  wire logic        clk,
   input  wire logic        rst_b,
   input  wire logic        tx_share,
   input  wire logic [15:0] tx_id,
   input  wire logic        rx_share,
   input  wire logic [15:0] rx_id,
   output logic [15:0]      cons_id,
   output logic [15:0]      prod_id
);
   // Consumer side of the far node loads the producer's fresh identifier
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) cons_id <= 16'hFFFF;
      else if (tx_share) cons_id <= tx_id;
   end

   // Producer side copies the identifier that this node generated
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) prod_id <= 16'hFFFF;
      else if (rx_share) prod_id <= rx_id;
   end
endmodule

// ===== tb/ccid_alloc_props.sv
`timescale 1ns/1ps
`include "ccid_defs.svh"

module ccid_alloc_props #(
   parameter int G1_IDS = 16,
   parameter int G2_IDS = 8,
   parameter int G3_IDS = 7
) (
   input  wire logic        CLK_SYS,
   input  wire logic        RST_B,
   input  wire logic [7:0]  REG_ADDR,
   input  wire logic [31:0] REG_WDATA,
   input  wire logic        REG_WR,
   input  wire logic        REG_RD,
   input  wire logic [31:0] REG_RDATA,
   input  wire logic [15:0] TX_ID,
   input  wire logic [15:0] RX_ID,
   input  wire logic        TX_ID_SHARE,
   input  wire logic        RX_ID_SHARE
);
   logic [5:0] node_q;

   // Shadow of own address; bench never rewrites it while established
   always_ff @(posedge CLK_SYS or negedge RST_B) begin
      if (!RST_B) node_q <= 6'h00;
      else if (REG_WR && REG_ADDR == `CCID_OFF_NODE) node_q <= REG_WDATA[5:0];
   end

   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (!RST_B);

   a_rdata_idle: assert property (!REG_RD |=> REG_RDATA == 32'h0)
      else $error("read data not zero outside read cycle");
   a_txid_range: assert property (TX_ID <= 16'h07F0 || TX_ID == 16'hFFFF)
      else $error("transmit identifier out of range");
   a_rxid_range: assert property (RX_ID <= 16'h07F0 || RX_ID == 16'hFFFF)
      else $error("receive identifier out of range");
   a_share_pulse: assert property (TX_ID_SHARE |=> !TX_ID_SHARE)
      else $error("transmit share longer than one cycle");
   a_share_cause: assert property (TX_ID_SHARE |-> $past(REG_WR, 3)
      && $past(REG_ADDR, 3) == `CCID_OFF_CMD && TX_ID <= 16'h07F0)
      else $error("transmit share without open");
   a_g1_source: assert property (TX_ID_SHARE && !TX_ID[10]
      |-> TX_ID[5:0] == node_q)
      else $error("group 1 identifier lacks own address");
   a_g2_source: assert property (TX_ID_SHARE && TX_ID[10:9] == 2'b10
      |-> TX_ID[8:3] == node_q)
      else $error("group 2 source identifier lacks own address");
   a_g3_source: assert property (TX_ID_SHARE && TX_ID[10:9] == 2'b11
      |-> TX_ID[5:0] == node_q)
      else $error("group 3 identifier lacks own address");
   a_rx_dest: assert property (RX_ID_SHARE |-> RX_ID[10:9] == 2'b10
      && RX_ID[8:3] == node_q)
      else $error("receive identifier badly formed");
   a_tx_hold: assert property ($changed(TX_ID)
      |-> $past(REG_WR) || $past(REG_WR, 2) || $past(REG_WR, 3)
      || $past(REG_WR, 4))
      else $error("transmit identifier changed without a write");
endmodule

bind ccid_alloc ccid_alloc_props #(
   .G1_IDS (G1_IDS),
   .G2_IDS (G2_IDS),
   .G3_IDS (G3_IDS)
) u_props (
   .CLK_SYS     (CLK_SYS),
   .RST_B       (RST_B),
   .REG_ADDR    (REG_ADDR),
   .REG_WDATA   (REG_WDATA),
   .REG_WR      (REG_WR),
   .REG_RD      (REG_RD),
   .REG_RDATA   (REG_RDATA),
   .TX_ID       (TX_ID),
   .RX_ID       (RX_ID),
   .TX_ID_SHARE (TX_ID_SHARE),
   .RX_ID_SHARE (RX_ID_SHARE)
);

// ===== tb/ccid_alloc_bench.sv
`timescale 1ns/1ps
`include "ccid_defs.svh"

`define CHK(nm, ex, got) \
   begin compares++; if ((got) !== (ex)) begin fails++; \
   $display("[ERR] %s exp %h got %h", nm, ex, got); end end

module ccid_alloc_bench;
   logic        clk_sys   = 1'b0;
   logic        rst_b     = 1'b0;
   logic [7:0]  reg_addr  = 8'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic        reg_wr    = 1'b0;
   logic        reg_rd    = 1'b0;
   logic [31:0] reg_rdata;
   logic [15:0] tx_id;
   logic [15:0] rx_id;
   logic        tx_share;
   logic        rx_share;
   logic [15:0] cons_id;
   logic [15:0] prod_id;
   logic [31:0] got;
   int          fails     = 0;
   int          compares  = 0;
   logic [7:0]  comm_tab [3] = '{8'h0F, 8'h2F, 8'h3F};
   logic [15:0] tx_tab [3]   = '{16'h0005, 16'h0428, 16'h0605};

   always #2.5 clk_sys = ~clk_sys;

   ccid_alloc dut (
      .CLK_SYS     (clk_sys),
      .RST_B       (rst_b),
      .REG_ADDR    (reg_addr),
      .REG_WDATA   (reg_wdata),
      .REG_WR      (reg_wr),
      .REG_RD      (reg_rd),
      .REG_RDATA   (reg_rdata),
      .TX_ID       (tx_id),
      .RX_ID       (rx_id),
      .TX_ID_SHARE (tx_share),
      .RX_ID_SHARE (rx_share)
   );

   ccid_peer peer (
      .clk      (clk_sys),
      .rst_b    (rst_b),
      .tx_share (tx_share),
      .tx_id    (tx_id),
      .rx_share (rx_share),
      .rx_id    (rx_id),
      .cons_id  (cons_id),
      .prod_id  (prod_id)
   );

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk_sys);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata;
   endtask

   // Open takes three cycles after the command edge to settle
   task automatic open_conn(input logic [7:0] comm, input logic [3:0] cmd);
      if (comm != 8'h00) wr(`CCID_OFF_COMM, {24'h0, comm});
      wr(`CCID_OFF_CMD, {28'h0, cmd});
      repeat (5) @(posedge clk_sys);
      #1;
   endtask

   task automatic close_conn;
      wr(`CCID_OFF_CMD, 32'h2);
      wr(`CCID_OFF_CMD, 32'h8);
      #1;
   endtask

   task automatic test_done;
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   initial begin
      repeat (4000) @(posedge clk_sys);
      fails++;
      test_done();
   end

   initial begin
      repeat (2) @(posedge clk_sys);
      rst_b <= 1'b1;
      rd(`CCID_OFF_COMM, got);
      `CHK("comm reset", 32'hFF, got)
      rd(`CCID_OFF_STAT, got);
      `CHK("stat reset", 32'h0, got)
      `CHK("tx reset", 16'hFFFF, tx_id)
      rd(8'hFC, got);
      `CHK("unmapped", 32'h0, got)
      $display("test reset done");

      wr(`CCID_OFF_NODE, 32'h5);
      for (int i = 0; i < 3; i++) begin
         open_conn(comm_tab[i], 4'h1);
         `CHK("tx id", tx_tab[i], tx_id)
         `CHK("peer rx", tx_tab[i], cons_id)
         `CHK("rx unused", 16'hFFFF, rx_id)
         close_conn();
         `CHK("tx closed", 16'hFFFF, tx_id)
      end
      $display("test production groups done");

      open_conn(8'h21, 4'h1);
      `CHK("tx g2", 16'h0428, tx_id)
      `CHK("rx g2", 16'h0429, rx_id)
      `CHK("peer tx", 16'h0429, prod_id)
      rd(`CCID_OFF_POOL, got);
      `CHK("pool held", 32'h00030000, got)
      wr(`CCID_OFF_COMM, 32'h0);
      rd(`CCID_OFF_COMM, got);
      `CHK("comm locked", 32'h21, got)
      rd(`CCID_OFF_STAT, got);
      `CHK("stat est err", 32'h3, got & 32'h3)
      close_conn();
      rd(`CCID_OFF_POOL, got);
      `CHK("pool freed", 32'h0, got)
      $display("test shared pool done");

      open_conn(8'h4F, 4'h1);
      `CHK("tx reserved", 16'hFFFF, tx_id)
      rd(`CCID_OFF_STAT, got);
      `CHK("err prod", 32'h2, got & 32'h2)
      close_conn();
      open_conn(8'hF5, 4'h1);
      `CHK("rx reserved", 16'hFFFF, rx_id)
      rd(`CCID_OFF_STAT, got);
      `CHK("err cons", 32'h2, got & 32'h2)
      close_conn();
      $display("test reserved done");

      wr(`CCID_OFF_DEST, 32'h9);
      open_conn(8'h1F, 4'h1);
      rd(`CCID_OFF_STAT, got);
      `CHK("tx wait", 32'h4, got & 32'h4)
      wr(`CCID_OFF_PEER_TX, 32'h0452);
      #1;
      `CHK("peer bad", 16'hFFFF, tx_id)
      wr(`CCID_OFF_PEER_TX, 32'h044A);
      #1;
      `CHK("peer good", 16'h044A, tx_id)
      close_conn();
      $display("test destination done");

      wr(`CCID_OFF_COMM, 32'hFF);
      open_conn(8'h00, 4'h5);
      rd(`CCID_OFF_COMM, got);
      `CHK("comm expl", 32'h33, got)
      `CHK("tx expl", 16'h0605, tx_id)
      rd(`CCID_OFF_STAT, got);
      `CHK("rx wait", 32'h9, got & 32'hD)
      wr(`CCID_OFF_PEER_RX, 32'h07F1);
      #1;
      `CHK("peer rx bad", 16'hFFFF, rx_id)
      wr(`CCID_OFF_PEER_RX, 32'h0605);
      #1;
      `CHK("peer rx good", 16'h0605, rx_id)
      close_conn();
      rd(`CCID_OFF_STAT, got);
      `CHK("stat closed", 32'h0, got)
      $display("test explicit done");
      test_done();
   end
endmodule
